// ===== test/parallel_port_ctrl_pin_mux_tb.sv
// self-checking bench for the control pin mux
`default_nettype none

module parallel_port_ctrl_pin_mux_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                       i_ref_clk = 1'b0;
  logic                       i_rstn = 1'b0;
  logic                       strap = 1'b0, hold = 1'b0, trst_n = 1'b1;
  logic                       emulation_pin_zero = 1'b0, emu1 = 1'b1, sel = 1'b0, dir_wr = 1'b0;
  logic                       hen = 1'b1, ext_oe = 1'b0, ext_val = 1'b0;
  logic [6:0]                 stb = 7'h7F;
  logic [1:0]                 dir = 2'h0, gout = 2'h0;
  ppc_pin_mux_pkg::mem_kind_t kind = ppc_pin_mux_pkg::MEM_ASYNC;
  wire logic                  pin0, pin1, out0, oe0, out1, oe1, io20, io21, fixed, emi;
  wire logic [1:0]            holder;
  int                         bad_count = 0;
  int                         samples_checked = 0;
  integer                     seed = 32'h2F3A;

  // 200 MHz clock
  always #2.5 i_ref_clk = ~i_ref_clk;

  parallel_port_ctrl_pin_mux u_parallel_port_ctrl_pin_mux (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_boot_function_strap(strap),
    .i_hold_request(hold), .i_test_reset_n(trst_n), .i_emulation_pin_zero(emulation_pin_zero),
    .i_emulation_pin_one_off(emu1), .i_control_pin_zero_in(pin0),
    .i_control_pin_one_in(pin1), .i_mem_kind(kind), .i_read_enable_select_bit(sel),
    .i_async_read_enable_n(stb[0]), .i_sync_address_strobe_n(stb[1]),
    .i_sdram_column_strobe_n(stb[2]), .i_sync_read_enable_n(stb[3]),
    .i_async_output_enable_n(stb[4]), .i_sync_output_enable_n(stb[5]),
    .i_sdram_row_strobe_n(stb[6]), .i_gpio_dir_write(dir_wr), .i_gpio_dir(dir),
    .i_gpio_out(gout), .i_holder_enable(hen), .o_control_pin_zero_out(out0),
    .o_control_pin_zero_oe(oe0), .o_control_pin_one_out(out1),
    .o_control_pin_one_oe(oe1), .o_bus_holder_enable(holder),
    .o_parallel_io_line_twenty_in(io20), .o_parallel_io_line_twenty_one_in(io21),
    .o_function_fixed(fixed), .o_emi_selected(emi));

  ppc_pad_partner u_ppc_pad_partner_zero (.i_clk(i_ref_clk), .i_dev_out(out0),
    .i_dev_oe(oe0), .i_ext_out(1'b0), .i_ext_oe(1'b0), .o_pin(pin0));
  ppc_pad_partner u_ppc_pad_partner_one (.i_clk(i_ref_clk), .i_dev_out(out1),
    .i_dev_oe(oe1), .i_ext_out(ext_val), .i_ext_oe(ext_oe), .o_pin(pin1));

  // expected strobe on pin zero for a memory kind
  function automatic logic exp_zero(input logic [1:0] k, input logic s, input logic [6:0] v);
    case (k)
      2'h0: return v[0];
      2'h1: return s ? v[3] : v[1];
      2'h2: return v[2];
      default: return 1'b1;
    endcase
  endfunction

  // expected strobe on pin one for a memory kind
  function automatic logic exp_one(input logic [1:0] k, input logic [6:0] v);
    case (k)
      2'h0: return v[4];
      2'h1: return v[5];
      2'h2: return v[6];
      default: return 1'b1;
    endcase
  endfunction

  task automatic check(input string what, input logic [1:0] seen, input logic [1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask

  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // reset with a strap level, then check the released function
  task automatic do_reset(input logic s);
    i_rstn = 1'b0;
    strap = s;
    tick(2);
    check("oe in reset", {oe1, oe0}, 2'h0);
    check("holder in reset", holder, 2'h3);
    tick(4);
    i_rstn = 1'b1;
    tick(2);
    check("fixed", {1'b0, fixed}, 2'h1);
    check("emi selected", {1'b0, emi}, {1'b0, s});
    check("oe after reset", {oe1, oe0}, s ? 2'h3 : 2'h0);
    if (s) check("idle strobes", {out1, out0}, 2'h3);
    // strap flip needs sync, latch and status flop to show if re-latched
    strap = ~s;
    tick(5);
    check("function kept", {1'b0, emi}, {1'b0, s});
  endtask

  initial begin
    do_reset(1'b1);
    // strobe routing for every memory kind, random levels
    for (int i = 0; i < 32; i++) begin
      kind = ppc_pin_mux_pkg::mem_kind_t'(i[1:0]);
      sel = 1'($random(seed));
      stb = 7'($random(seed));
      tick(1);
      check("pin zero strobe", {1'b0, out0}, {1'b0, exp_zero(kind, sel, stb)});
      check("pin one strobe", {1'b0, out1}, {1'b0, exp_one(kind, stb)});
    end
    hen = 1'b0;
    tick(1);
    check("holder off", holder, 2'h0);
    hen = 1'b1;
    tick(1);
    check("holder on", holder, 2'h3);
    hold = 1'b1;
    tick(3);
    check("oe in hold", {oe1, oe0}, 2'h0);
    hold = 1'b0;
    tick(3);
    check("oe after hold", {oe1, oe0}, 2'h3);
    {trst_n, emulation_pin_zero, emu1} = 3'h2;
    tick(3);
    check("oe in off mode", {oe1, oe0}, 2'h0);
    {trst_n, emulation_pin_zero, emu1} = 3'h5;
    tick(3);
    check("oe after off mode", {oe1, oe0}, 2'h3);
    do_reset(1'b0);
    // pin zero as output, pin one read back from the far side
    gout = 2'($random(seed));
    dir = 2'h1;
    dir_wr = 1'b1;
    ext_oe = 1'b1;
    tick(1);
    dir_wr = 1'b0;
    tick(1);
    check("gpio oe", {oe1, oe0}, 2'h1);
    check("gpio out", {1'b0, out0}, {1'b0, gout[0]});
    for (int i = 0; i < 6; i++) begin
      ext_val = 1'($random(seed));
      tick(3);
      check("read back one", {1'b0, io21}, {1'b0, ext_val});
      check("read back zero", {1'b0, io20}, {1'b0, gout[0]});
    end
    // both lines as outputs, far side released
    dir = 2'h3;
    dir_wr = 1'b1;
    ext_oe = 1'b0;
    tick(1);
    dir_wr = 1'b0;
    tick(1);
    check("gpio oe both", {oe1, oe0}, 2'h3);
    check("gpio out both", {out1, out0}, gout);
    tick(3);
    check("read back both", {io21, io20}, gout);
    give_verdict();
  end
endmodule

`default_nettype wire

// ===== test/ppc_pad_partner.sv
// far-side pad model that resolves the level of one control pin
`default_nettype none

module ppc_pad_partner (
  // clock
  input  wire logic i_clk,
  // device pad drive
  input  wire logic i_dev_out,
  input  wire logic i_dev_oe,
  // far-side drive
  input  wire logic i_ext_out,
  input  wire logic i_ext_oe,
  // resolved pin level
  output logic      o_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last = 1'b0;
  // remember the last driven level
  always_ff @(posedge i_clk) begin
    if (i_dev_oe || i_ext_oe) last <= o_pin;
  end
  // a released pin shows the inverse of its last level, never a kind value
  always_comb begin
    if (i_dev_oe) o_pin = i_dev_out;
    else if (i_ext_oe) o_pin = i_ext_out;
    else o_pin = ~last;
  end
endmodule

`default_nettype wire

// ===== verilog/parallel_port_ctrl_pin_mux.sv
// function select and pad control for two parallel-port control pins
//
// Operation
// - strap low gives gpio, high gives strobe
// - function fixed at reset release, kept after
// - gpio function leaves reset as input
// - strobe function floats in reset, drives 1
// - pin zero: read, address, column strobes
// - pin one: output enables, row strobe
// - both pins float during bus hold
// - both pins float in off mode
// - bus holders default on, software switchable
`include "ppc_pin_mux_consts.svh"
`default_nettype none

module parallel_port_ctrl_pin_mux (
  // clock and reset
  input  wire logic                           i_ref_clk,
  input  wire logic                           i_rstn,
  // pin-level inputs from outside
  input  wire logic                           i_boot_function_strap,
  input  wire logic                           i_hold_request,
  input  wire logic                           i_test_reset_n,
  input  wire logic                           i_emulation_pin_zero,
  input  wire logic                           i_emulation_pin_one_off,
  input  wire logic                           i_control_pin_zero_in,
  input  wire logic                           i_control_pin_one_in,
  // memory kind, read-enable select bit and memory-interface strobes (strobes active low)
  input  wire ppc_pin_mux_pkg::mem_kind_t     i_mem_kind,
  input  wire logic                           i_read_enable_select_bit,
  input  wire logic                           i_async_read_enable_n,
  input  wire logic                           i_sync_address_strobe_n,
  input  wire logic                           i_sdram_column_strobe_n,
  input  wire logic                           i_sync_read_enable_n,
  input  wire logic                           i_async_output_enable_n,
  input  wire logic                           i_sync_output_enable_n,
  input  wire logic                           i_sdram_row_strobe_n,
  // general-purpose line control
  input  wire logic                           i_gpio_dir_write,
  input  wire logic [1:0]                     i_gpio_dir,
  input  wire logic [1:0]                     i_gpio_out,
  // bus holder control from the external bus control register
  input  wire logic                           i_holder_enable,
  // pad drive
  output logic                                o_control_pin_zero_out,
  output logic                                o_control_pin_zero_oe,
  output logic                                o_control_pin_one_out,
  output logic                                o_control_pin_one_oe,
  output logic [1:0]                          o_bus_holder_enable,
  // read-back to general-purpose logic
  output logic                                o_parallel_io_line_twenty_in,
  output logic                                o_parallel_io_line_twenty_one_in,
  // status
  output logic                                o_function_fixed,
  output logic                                o_emi_selected
);

  logic [`PPM_SYNC_WIDTH-1:0] pins_sync;
  ppc_pin_mux_pkg::pin_fn_t   pin_fn;
  logic [1:0]                 gpio_dir;
  logic                       off_mode;
  logic                       float_pins;
  logic                       strobe_zero;
  logic                       strobe_one;
  logic                       next_zero_out;
  logic                       next_zero_oe;
  logic                       next_one_out;
  logic                       next_one_oe;

  // every pin-level input passes two flops first
  pin_sync2 #(
    .WIDTH (`PPM_SYNC_WIDTH)
  ) u_pin_sync (
    .i_clk   (i_ref_clk),
    .i_async ({i_control_pin_one_in, i_control_pin_zero_in, i_emulation_pin_one_off,
               i_emulation_pin_zero, i_test_reset_n, i_hold_request,
               i_boot_function_strap}),
    .o_sync  (pins_sync)
  );

  // off mode and hold both release the pads
  assign off_mode   = !pins_sync[`PPM_SYNC_TRST_N] && pins_sync[`PPM_SYNC_EMULATION_PIN_ZERO]
                      && !pins_sync[`PPM_SYNC_EMULATION_PIN_ONE_OFF];
  assign float_pins = pins_sync[`PPM_SYNC_HOLD] || off_mode;

  // strap caught on the first edge after release, then frozen
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pin_fn <= ppc_pin_mux_pkg::FN_UNSET;
    end else if (pin_fn == ppc_pin_mux_pkg::FN_UNSET) begin
      pin_fn <= (pins_sync[`PPM_SYNC_STRAP] == `PPM_STRAP_EMI_LEVEL)
                ? ppc_pin_mux_pkg::FN_EMI : ppc_pin_mux_pkg::FN_GPIO;
    end
  end

  // general-purpose direction, input after reset
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      gpio_dir <= `PPM_GPIO_DIR_RST;
    end else if (i_gpio_dir_write) begin
      gpio_dir <= i_gpio_dir;
    end
  end

  // pin zero strobe role by memory kind and select bit
  always_comb begin
    case (i_mem_kind)
      ppc_pin_mux_pkg::MEM_ASYNC: strobe_zero = i_async_read_enable_n;
      ppc_pin_mux_pkg::MEM_SYNC:  strobe_zero = i_read_enable_select_bit
                                                ? i_sync_read_enable_n
                                                : i_sync_address_strobe_n;
      ppc_pin_mux_pkg::MEM_SDRAM: strobe_zero = i_sdram_column_strobe_n;
      default:                    strobe_zero = `PPM_STROBE_IDLE;
    endcase
  end

  // pin one strobe role by memory kind
  always_comb begin
    case (i_mem_kind)
      ppc_pin_mux_pkg::MEM_ASYNC: strobe_one = i_async_output_enable_n;
      ppc_pin_mux_pkg::MEM_SYNC:  strobe_one = i_sync_output_enable_n;
      ppc_pin_mux_pkg::MEM_SDRAM: strobe_one = i_sdram_row_strobe_n;
      default:                    strobe_one = `PPM_STROBE_IDLE;
    endcase
  end

  // pad drive for the function in force
  always_comb begin
    case (pin_fn)
      ppc_pin_mux_pkg::FN_GPIO: begin
        next_zero_out = i_gpio_out[0];
        next_one_out  = i_gpio_out[1];
        next_zero_oe  = gpio_dir[0];
        next_one_oe   = gpio_dir[1];
      end
      ppc_pin_mux_pkg::FN_EMI: begin
        next_zero_out = strobe_zero;
        next_one_out  = strobe_one;
        next_zero_oe  = 1'b1;
        next_one_oe   = 1'b1;
      end
      default: begin
        next_zero_out = `PPM_PIN_OUT_RST;
        next_one_out  = `PPM_PIN_OUT_RST;
        next_zero_oe  = 1'b0;
        next_one_oe   = 1'b0;
      end
    endcase
    if (float_pins) begin
      next_zero_oe = 1'b0;
      next_one_oe  = 1'b0;
    end
  end

  // pad output flops, released during reset
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_control_pin_zero_out <= `PPM_PIN_OUT_RST;
      o_control_pin_one_out  <= `PPM_PIN_OUT_RST;
      o_control_pin_zero_oe  <= 1'b0;
      o_control_pin_one_oe   <= 1'b0;
    end else begin
      o_control_pin_zero_out <= next_zero_out;
      o_control_pin_one_out  <= next_one_out;
      o_control_pin_zero_oe  <= next_zero_oe;
      o_control_pin_one_oe   <= next_one_oe;
    end
  end

  // bus holders on by default, software may switch them
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_bus_holder_enable <= `PPM_HOLDER_RST;
    end else begin
      o_bus_holder_enable <= {2{i_holder_enable}};
    end
  end

  // read-back and status
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_parallel_io_line_twenty_in     <= 1'b0;
      o_parallel_io_line_twenty_one_in <= 1'b0;
      o_function_fixed                 <= 1'b0;
      o_emi_selected                   <= 1'b0;
    end else begin
      o_parallel_io_line_twenty_in     <= pins_sync[`PPM_SYNC_PIN0];
      o_parallel_io_line_twenty_one_in <= pins_sync[`PPM_SYNC_PIN1];
      o_function_fixed                 <= (pin_fn != ppc_pin_mux_pkg::FN_UNSET);
      o_emi_selected                   <= (pin_fn == ppc_pin_mux_pkg::FN_EMI);
    end
  end

  // checks
  default clocking chk_cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rstn);

  sequence fn_catch_s;
    pin_fn == ppc_pin_mux_pkg::FN_UNSET;
  endsequence

  sequence emi_live_s;
    pin_fn == ppc_pin_mux_pkg::FN_EMI && !float_pins;
  endsequence

  strap_select_a: assert property (fn_catch_s |=> pin_fn ==
      ($past(pins_sync[`PPM_SYNC_STRAP]) ? ppc_pin_mux_pkg::FN_EMI : ppc_pin_mux_pkg::FN_GPIO))
    else $error("function does not follow strap");

  fn_frozen_a: assert property (pin_fn != ppc_pin_mux_pkg::FN_UNSET |=> $stable(pin_fn))
    else $error("function changed after release");

  gpio_input_a: assert property (fn_catch_s ##1 (pin_fn == ppc_pin_mux_pkg::FN_GPIO
      && !$past(i_gpio_dir_write)) |=> !o_control_pin_zero_oe && !o_control_pin_one_oe)
    else $error("gpio line drives after reset");

  unset_float_a: assert property (fn_catch_s |=> !o_control_pin_zero_oe
      && !o_control_pin_one_oe && o_control_pin_zero_out)
    else $error("pin driven before function fixed");

  emi_drive_a: assert property (fn_catch_s ##1 emi_live_s |=> o_control_pin_zero_oe
      && o_control_pin_one_oe)
    else $error("strobe pin not driven after reset");

  zero_route_a: assert property ((emi_live_s
      and (i_mem_kind == ppc_pin_mux_pkg::MEM_SYNC))
      |=> o_control_pin_zero_out == ($past(i_read_enable_select_bit)
          ? $past(i_sync_read_enable_n) : $past(i_sync_address_strobe_n)))
    else $error("pin zero strobe role wrong");

  one_route_a: assert property ((emi_live_s
      and (i_mem_kind == ppc_pin_mux_pkg::MEM_SDRAM))
      |=> o_control_pin_one_out == $past(i_sdram_row_strobe_n))
    else $error("pin one strobe role wrong");

  hold_float_a: assert property (pins_sync[`PPM_SYNC_HOLD]
      |=> !o_control_pin_zero_oe && !o_control_pin_one_oe)
    else $error("pin driven during hold");

  off_float_a: assert property (!pins_sync[`PPM_SYNC_TRST_N]
      && pins_sync[`PPM_SYNC_EMULATION_PIN_ZERO] && !pins_sync[`PPM_SYNC_EMULATION_PIN_ONE_OFF]
      |=> !o_control_pin_zero_oe && !o_control_pin_one_oe)
    else $error("pin driven in off mode");

  holder_follow_a: assert property (##1 $changed(i_holder_enable)
      |=> o_bus_holder_enable == {2{$past(i_holder_enable)}})
    else $error("bus holder enable not updated");

endmodule

`default_nettype wire

// ===== verilog/pin_sync2.sv
// two-flop synchroniser for pin-level inputs
`default_nettype none

module pin_sync2 #(
  parameter int WIDTH = 1
) (
  // clock
  input  wire logic             i_clk,
  // asynchronous levels
  input  wire logic [WIDTH-1:0] i_async,
  // synchronised levels
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] stage_one;

  // no reset, so the strap is already valid when reset is released
  always_ff @(posedge i_clk) begin
    stage_one <= i_async;
    o_sync    <= stage_one;
  end

endmodule

`default_nettype wire

// ===== verilog/ppc_pin_mux_consts.svh
// constants for the parallel-port control pin mux
`ifndef PPC_PIN_MUX_CONSTS_SVH
`define PPC_PIN_MUX_CONSTS_SVH

// strap level that picks the memory-interface function
`define PPM_STRAP_EMI_LEVEL   1'b1
// idle level of a memory-interface strobe after reset
`define PPM_STROBE_IDLE       1'b1
// bus holders come out of reset enabled
`define PPM_HOLDER_RST        2'h3
// general-purpose lines come out of reset as inputs
`define PPM_GPIO_DIR_RST      2'h0
// released-pin value while the pin is not driven
`define PPM_PIN_OUT_RST       1'b1
// number of synchronised pin inputs and their positions
`define PPM_SYNC_WIDTH        7
`define PPM_SYNC_STRAP        0
`define PPM_SYNC_HOLD         1
`define PPM_SYNC_TRST_N       2
`define PPM_SYNC_EMULATION_PIN_ZERO         3
`define PPM_SYNC_EMULATION_PIN_ONE_OFF     4
`define PPM_SYNC_PIN0         5
`define PPM_SYNC_PIN1         6

`endif

// ===== verilog/ppc_pin_mux_pkg.sv
// types for the parallel-port control pin mux
`default_nettype none

package ppc_pin_mux_pkg;

  // function held by both control pins
  typedef enum logic [1:0] {
    FN_UNSET = 2'b00,
    FN_GPIO  = 2'b01,
    FN_EMI   = 2'b10
  } pin_fn_t;

  // kind of memory the current access targets
  typedef enum logic [1:0] {
    MEM_ASYNC = 2'b00,
    MEM_SYNC  = 2'b01,
    MEM_SDRAM = 2'b10
  } mem_kind_t;

endpackage

`default_nettype wire
